// file: design/rcf_pkg.sv
package rcf_pkg;
  localparam logic [31:0] RCF_CAUSE_OFFSET  = 32'h0000_0000;
  localparam int          RCF_ADDR_LSB      = 2;
  localparam int          RCF_ADDR_W        = 12;
  localparam int          RCF_FLAGS_W       = 16;
  localparam int          RCF_TRAP_BIT      = 15;
  localparam int          RCF_ILLOP_BIT     = 14;
  localparam int          RCF_DSLEEP_BIT    = 10;
  localparam int          RCF_CFGMM_BIT     = 9;
  localparam int          RCF_EXTPIN_BIT    = 7;
  localparam int          RCF_SWRST_BIT     = 6;
  localparam int          RCF_SWDT_BIT      = 5;
  localparam int          RCF_WATCHDOG_EXPIRED_FLAG_BIT      = 4;
  localparam int          RCF_SLEEP_BIT     = 3;
  localparam int          RCF_IDLE_BIT      = 2;
  localparam int          RCF_BOR_BIT       = 1;
  localparam int          RCF_POR_BIT       = 0;
  localparam logic [15:0] RCF_FLAGS_RESET   = 16'h0003;
  localparam logic [15:0] RCF_WRITABLE_MASK = 16'hc6ff;
  localparam logic [1:0]  RCF_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RCF_RESP_SLVERR   = 2'h2;
  localparam int          RCF_SYNC_W        = 2;

  typedef enum logic [1:0] {
    RCF_RD_IDLE = 2'b01,
    RCF_RD_RESP = 2'b10
  } rcf_rd_state_type;
endpackage

// file: design/rcf_sync.sv
`timescale 1ns/1ps
module rcf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,    // system clock
  input  wire logic             aresetn, // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in, // levels from outside the clock domain
  output logic      [WIDTH-1:0] sync_out  // resynchronised levels
);
  logic [WIDTH-1:0] meta_ff;

  // meta_ff feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // rcf_sync

// file: design/rcf_reset_cause.sv
`timescale 1ns/1ps
module rcf_reset_cause (
  input  wire logic                             aclk,                 // 25 MHz clock
  input  wire logic                             aresetn,              // power-on reset, low
  input  wire logic [rcf_pkg::RCF_ADDR_W-1:0]   s_axi_awaddr,         // write address
  input  wire logic                             s_axi_awvalid,        // write address valid
  output logic                                  s_axi_awready,        // write address ready
  input  wire logic [31:0]                      s_axi_wdata,          // write data
  input  wire logic [3:0]                       s_axi_wstrb,          // byte strobes
  input  wire logic                             s_axi_wvalid,         // write data valid
  output logic                                  s_axi_wready,         // write data ready
  output logic [1:0]                            s_axi_bresp,          // write response
  output logic                                  s_axi_bvalid,         // write response valid
  input  wire logic                             s_axi_bready,         // write response ready
  input  wire logic [rcf_pkg::RCF_ADDR_W-1:0]   s_axi_araddr,         // read address
  input  wire logic                             s_axi_arvalid,        // read address valid
  output logic                                  s_axi_arready,        // read address ready
  output logic [31:0]                           s_axi_rdata,          // read data
  output logic [1:0]                            s_axi_rresp,          // read response
  output logic                                  s_axi_rvalid,         // read data valid
  input  wire logic                             s_axi_rready,         // read data ready
  input  wire logic                             trap_conflict_evt,    // trap conflict pulse
  input  wire logic                             illegal_op_evt,       // illegal opcode pulse
  input  wire logic                             config_mismatch_evt,  // config mismatch pulse
  input  wire logic                             master_clear_pin,     // pin reset level, async
  input  wire logic                             soft_reset_evt,       // reset instruction pulse
  input  wire logic                             wdt_timeout_evt,      // watchdog time-out pulse
  input  wire logic                             power_save_instruction_sleep_evt,     // power-save sleep pulse
  input  wire logic                             power_save_instruction_idle_evt,      // power-save idle pulse
  input  wire logic                             brownout_in,          // brown-out level, async
  input  wire logic                             deep_sleep_arm,       // deep sleep armed level
  input  wire logic                             watchdog_fuse_enable, // fuse, 1 forces wdt on
  output logic [rcf_pkg::RCF_FLAGS_W-1:0]       reset_cause,          // flag register copy
  output logic                                  watchdog_enable       // effective wdt enable
);
  import rcf_pkg::*;

  logic [RCF_FLAGS_W-1:0]  reset_cause_ff;
  logic [RCF_FLAGS_W-1:0]  nxt_reset_cause;
  logic [RCF_FLAGS_W-1:0]  hw_set;
  logic [RCF_FLAGS_W-1:0]  hw_clr;
  logic [RCF_FLAGS_W-1:0]  wr_mask;
  logic [RCF_SYNC_W-1:0]   pin_sync;
  logic [RCF_ADDR_W-1:0]   awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    aw_held_ff;
  logic                    w_held_ff;
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    write_fire;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  rcf_rd_state_type        rd_state_ff;
  logic [31:0]             rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic                    watchdog_enable_ff;

  function automatic logic rcf_addr_hit(input logic [RCF_ADDR_W-1:0] addr);
    rcf_addr_hit = (addr[RCF_ADDR_W-1:RCF_ADDR_LSB] ==
                    RCF_CAUSE_OFFSET[RCF_ADDR_W-1:RCF_ADDR_LSB]);
  endfunction

  // pin and brown-out levels come from outside the clock domain
  rcf_sync #(
    .WIDTH (RCF_SYNC_W)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({brownout_in, master_clear_pin}),
    .sync_out (pin_sync)
  );

  // write channel: address and data taken in either order, answered once both are held
  assign write_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && !aw_held_ff) begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff  <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (s_axi_wvalid && !w_held_ff) begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RCF_RESP_OKAY;
    end else if (write_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= rcf_addr_hit(awaddr_ff) ? RCF_RESP_OKAY : RCF_RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // each ready has a flop of its own so no port sits behind a gate
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= RCF_RD_IDLE;
      arready_ff  <= 1'b1;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= '0;
      rresp_ff    <= RCF_RESP_OKAY;
    end else begin
      case (rd_state_ff)
        RCF_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_ff <= RCF_RD_RESP;
            arready_ff  <= 1'b0;
            rvalid_ff   <= 1'b1;
            if (rcf_addr_hit(s_axi_araddr)) begin
              rdata_ff <= {16'h0000, reset_cause_ff};
              rresp_ff <= RCF_RESP_OKAY;
            end else begin
              rdata_ff <= 32'h0000_0000;
              rresp_ff <= RCF_RESP_SLVERR;
            end
          end
        end
        RCF_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_ff <= RCF_RD_IDLE;
            arready_ff  <= 1'b1;
            rvalid_ff   <= 1'b0;
          end
        end
        default: begin
          rd_state_ff <= RCF_RD_IDLE;
          arready_ff  <= 1'b1;
          rvalid_ff   <= 1'b0;
        end
      endcase
    end
  end

  // the state is mirrored by two flops so each handshake port is a flop output
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // hardware events
  always_comb begin
    hw_set                 = '0;
    hw_clr                 = '0;
    hw_set[RCF_ILLOP_BIT]  = illegal_op_evt;
    hw_set[RCF_TRAP_BIT]   = trap_conflict_evt;
    hw_set[RCF_CFGMM_BIT]  = config_mismatch_evt;
    hw_set[RCF_EXTPIN_BIT] = pin_sync[0];
    hw_set[RCF_SWRST_BIT]  = soft_reset_evt;
    hw_set[RCF_WATCHDOG_EXPIRED_FLAG_BIT]   = wdt_timeout_evt;
    hw_clr[RCF_WATCHDOG_EXPIRED_FLAG_BIT]   = power_save_instruction_sleep_evt | power_save_instruction_idle_evt;
    hw_set[RCF_SLEEP_BIT]  = power_save_instruction_sleep_evt;
    hw_set[RCF_IDLE_BIT]   = power_save_instruction_idle_evt;
    hw_set[RCF_BOR_BIT]    = pin_sync[1];
    hw_set[RCF_DSLEEP_BIT] = power_save_instruction_sleep_evt & deep_sleep_arm;
  end

  assign wr_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}} & RCF_WRITABLE_MASK;

  // a software write only stores bits; it never requests a reset
  always_comb begin
    nxt_reset_cause = reset_cause_ff;
    if (write_fire && rcf_addr_hit(awaddr_ff)) begin
      nxt_reset_cause = (reset_cause_ff & ~wr_mask) | (wdata_ff[15:0] & wr_mask);
    end
    nxt_reset_cause = (nxt_reset_cause & ~hw_clr) | hw_set;
  end

  // only the power-on reset reloads the flags; other resets arrive as events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_ff <= RCF_FLAGS_RESET;
    end else begin
      reset_cause_ff <= nxt_reset_cause;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_enable_ff <= 1'b0;
    end else begin
      watchdog_enable_ff <= watchdog_fuse_enable | reset_cause_ff[RCF_SWDT_BIT];
    end
  end

  assign reset_cause     = reset_cause_ff;
  assign watchdog_enable = watchdog_enable_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  por_value_a: assert property ($rose(aresetn) |-> reset_cause_ff == RCF_FLAGS_RESET)
    else $error("flags not at power-on value");
  illop_set_a: assert property (illegal_op_evt |=> reset_cause_ff[RCF_ILLOP_BIT])
    else $error("illegal op flag not set");
  trap_set_a: assert property (trap_conflict_evt |=> reset_cause_ff[RCF_TRAP_BIT])
    else $error("trap flag not set");
  watchdog_expired_flag_clear_a: assert property ((power_save_instruction_idle_evt || power_save_instruction_sleep_evt) && !wdt_timeout_evt
    && !write_fire |=> !reset_cause_ff[RCF_WATCHDOG_EXPIRED_FLAG_BIT])
    else $error("watchdog flag not cleared by power save");
  sleep_set_a: assert property (power_save_instruction_sleep_evt |=> reset_cause_ff[RCF_SLEEP_BIT]
    && (!reset_cause_ff[RCF_WATCHDOG_EXPIRED_FLAG_BIT] || $past(wdt_timeout_evt)))
    else $error("sleep flag wrong");
  idle_set_a: assert property (power_save_instruction_idle_evt |=> reset_cause_ff[RCF_IDLE_BIT])
    else $error("idle flag not set");
  dsleep_set_a: assert property (power_save_instruction_sleep_evt && deep_sleep_arm
    |=> reset_cause_ff[RCF_DSLEEP_BIT])
    else $error("deep sleep flag not set");
  // async levels need two synchroniser edges, then the flag register edge
  bor_set_a: assert property ($rose(brownout_in)
    |-> ##3 reset_cause_ff[RCF_BOR_BIT])
    else $error("brown-out flag not set");
  sw_write_a: assert property (write_fire && rcf_addr_hit(awaddr_ff) && wstrb_ff[1:0] == 2'h3
    && hw_set == '0 && hw_clr == '0 |=> reset_cause_ff == (wdata_ff[15:0] & RCF_WRITABLE_MASK))
    else $error("software write not stored");
  set_wins_a: assert property (write_fire && wstrb_ff[1] && !wdata_ff[RCF_TRAP_BIT]
    && trap_conflict_evt |=> reset_cause_ff[RCF_TRAP_BIT])
    else $error("hardware set lost to software clear");
  flags_hold_a: assert property (!write_fire && hw_set == '0 && hw_clr == '0
    |=> $stable(reset_cause_ff))
    else $error("flags changed without cause");
  fuse_force_a: assert property (watchdog_fuse_enable |=> watchdog_enable)
    else $error("fuse did not force watchdog");
  soft_wdt_a: assert property (!watchdog_fuse_enable
    |=> watchdog_enable == $past(reset_cause_ff[RCF_SWDT_BIT]))
    else $error("watchdog enable does not follow bit 5");
  pin_set_a: assert property ($rose(master_clear_pin)
    |-> ##3 reset_cause_ff[RCF_EXTPIN_BIT])
    else $error("pin reset flag not set");
  cfg_set_a: assert property (config_mismatch_evt
    |=> reset_cause_ff[RCF_CFGMM_BIT])
    else $error("mismatch flag not set");
  swrst_set_a: assert property (soft_reset_evt |=> reset_cause_ff[RCF_SWRST_BIT])
    else $error("soft reset flag not set");
  watchdog_expired_flag_set_a: assert property (wdt_timeout_evt
    |=> reset_cause_ff[RCF_WATCHDOG_EXPIRED_FLAG_BIT])
    else $error("watchdog flag not set");
  // an unmapped write answers with an error and leaves the flags alone
  unmapped_keep_a: assert property (write_fire && !rcf_addr_hit(awaddr_ff)
    && hw_set == '0 && hw_clr == '0 |=> $stable(reset_cause_ff))
    else $error("unmapped write changed the flags");
  // the answer follows one edge after both write halves are held
  write_resp_a: assert property (write_fire
    |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write answer missing");
  read_data_a: assert property (s_axi_arvalid && s_axi_arready && rcf_addr_hit(s_axi_araddr)
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(reset_cause_ff)})
    else $error("read data differs from flags");

  write_seen_c: cover property (write_fire ##1 s_axi_bvalid && s_axi_bready);
  read_seen_c:  cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
  collide_c:    cover property (write_fire && trap_conflict_evt && !wdata_ff[RCF_TRAP_BIT]);
  dsleep_c:     cover property (power_save_instruction_sleep_evt && deep_sleep_arm);
  async_c:      cover property ($rose(brownout_in) || $rose(master_clear_pin));
endmodule // rcf_reset_cause

// file: testbench/rcf_reset_cause_tb.sv
`timescale 1ns/1ps
module rcf_reset_cause_tb;
  import rcf_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  ev;
  logic        arm, fuse, wdt_en;
  logic [15:0] cause;
  int          errors, n_checks;
  int          bits [9] = '{15, 14, 9, 7, 6, 4, 3, 2, 1};

  rcf_reset_cause rcf_reset_cause_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trap_conflict_evt(ev[0]), .illegal_op_evt(ev[1]), .config_mismatch_evt(ev[2]),
    .master_clear_pin(ev[3]), .soft_reset_evt(ev[4]), .wdt_timeout_evt(ev[5]),
    .power_save_instruction_sleep_evt(ev[6]), .power_save_instruction_idle_evt(ev[7]), .brownout_in(ev[8]),
    .deep_sleep_arm(arm), .watchdog_fuse_enable(fuse), .reset_cause(cause),
    .watchdog_enable(wdt_en));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // every wait is bounded; a hung handshake ends the run as a mismatch
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) begin
      errors++;
      print_verdict();
    end
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdr(input logic [11:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rd = rdata;
    rready <= 1'b0;
    if (n >= 40) begin
      errors++;
      print_verdict();
    end
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rchk(input string nm, input logic [15:0] e);
    rdr(RCF_CAUSE_OFFSET[11:0], RCF_RESP_OKAY);
    chk(nm, rd, {16'h0, e});
  endtask

  task automatic clr();
    wr(RCF_CAUSE_OFFSET[11:0], 32'h0, 4'h3, RCF_RESP_OKAY);
  endtask

  // one-cycle event; four edges cover the two-flop path of the async inputs
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {ev, arm, fuse} = '0;
    errors = 0;
    n_checks = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("flags after reset", 16'h0003);
    chk("wdt after reset", {31'h0, wdt_en}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      clr();
      rchk("software clear", 16'h0000);
      pulse(i);
      rchk("event flag", 16'h0001 << bits[i]);
    end
    clr();
    arm <= 1'b1;
    pulse(6);
    arm <= 1'b0;
    rchk("deep sleep", 16'h0408);
    wr(RCF_CAUSE_OFFSET[11:0], 32'h0010, 4'h3, RCF_RESP_OKAY);
    rchk("software set", 16'h0010);
    pulse(7);
    rchk("power save clear", 16'h0004);
    $display("test events done");
    // trap pulse sampled only at the edge where the clearing write lands
    fork
      clr();
      begin
        repeat (2) @(posedge aclk);
        ev[0] <= 1'b1;
        @(posedge aclk);
        ev[0] <= 1'b0;
      end
    join
    rchk("set beats clear", 16'h8000);
    wr(RCF_CAUSE_OFFSET[11:0], 32'hffff, 4'h1, RCF_RESP_OKAY);
    rchk("low strobe", 16'h80ff);
    wr(RCF_CAUSE_OFFSET[11:0], 32'h0, 4'h2, RCF_RESP_OKAY);
    rchk("high strobe", 16'h00ff);
    wr(RCF_CAUSE_OFFSET[11:0], 32'hffff, 4'h3, RCF_RESP_OKAY);
    rchk("writable bits", RCF_WRITABLE_MASK);
    pulse(4);
    rchk("soft reset keeps", 16'hc6ff);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("power-on clear", 16'h0003);
    $display("test sticky done");
    wr(RCF_CAUSE_OFFSET[11:0], 32'h0020, 4'h3, RCF_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("wdt on", {31'h0, wdt_en}, 32'h1);
    clr();
    repeat (2) @(posedge aclk);
    chk("wdt off", {31'h0, wdt_en}, 32'h0);
    fuse <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("wdt forced", {31'h0, wdt_en}, 32'h1);
    fuse <= 1'b0;
    $display("test watchdog done");
    wr(12'h004, 32'hffff, 4'h3, RCF_RESP_SLVERR);
    rdr(12'h004, RCF_RESP_SLVERR);
    chk("unmapped data", rd, 32'h0);
    rchk("unmapped no effect", 16'h0000);
    $display("test unmapped done");
    print_verdict();
  end
endmodule // rcf_reset_cause_tb
